/* rtl/supply_monitor_pkg.sv */
// constants and types shared by the supply monitor design
// Summary of operation
// - three-bit trip select: 000 is 2.0 V up to 111 at 4.0 V
// - bit 5 reads 1 while supply is below the selected threshold
// - bit 4 enables the detector; 0 powers the detector down
// - bits 7, 6 and 3 read zero and ignore writes
// - enabling the detector also enables its internal reference
// - request flag sets after the qualifying delay of a low flag, or when software writes it to 1
// - setting the request flag wakes the core from sleep and idle
// - vectored irq needs global, own, group enables and stack room
// - servicing clears global enable and group request, not own flag
// - wake-up follows a rising request flag, whatever the enables
package supply_monitor_pkg;
   // register byte addresses
   localparam logic [7:0] ctrl_addr = 8'h00;
   localparam logic [7:0] irq_ctrl_addr = 8'h04;
   localparam logic [7:0] status_addr = 8'h08;
   localparam logic [7:0] mask_addr = 8'h0c;
   // control register fields
   localparam int flag_bit = 5;
   localparam int enable_bit = 4;
   localparam int level_lsb = 0;
   localparam int level_w = 3;
   localparam logic [7:0] ctrl_write_mask = 8'h17;
   localparam logic [7:0] ctrl_reset = 8'h00;
   // irq control register fields
   localparam int req_bit = 0;
   localparam int own_en_bit = 1;
   localparam int group_en_bit = 2;
   localparam int global_en_bit = 3;
   localparam int group_req_bit = 4;
   // status register fields
   localparam int st_request_bit = 0;
   localparam int st_wake_bit = 1;
   localparam int st_vector_bit = 2;
   localparam int st_w = 3;
   // qualifying delay
   localparam int clk_mhz = 20;
   localparam int qualify_us = 20;
   localparam int qualify_cycles = qualify_us * clk_mhz;
   localparam int cnt_w = 16;
   // axi responses
   localparam logic [1:0] resp_okay = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;

   typedef enum logic [1:0] {qual_idle, qual_count, qual_done} qual_state_e;

   function automatic logic [7:0] ctrl_image(input logic [7:0] stored,
                                             input logic flag);
      logic [7:0] img;
      img = stored & ctrl_write_mask;
      img[flag_bit] = flag;
      return img;
   endfunction
endpackage

/* rtl/level_sync.sv */
// two-stage synchroniser for the comparator output
`timescale 1ns/10ps
module level_sync
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // level in and out
   input wire logic raw_in,
   output logic sync_out
);
   typedef struct packed
   {
      logic stage1;
      logic stage2;
   } sync_s;
   sync_s r;
   sync_s next_r;

   always_comb
   begin
      next_r.stage1 = raw_in;
      next_r.stage2 = r.stage1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         r <= '0;
      else
         r <= next_r;
   end

   assign sync_out = r.stage2;
endmodule // level_sync

/* rtl/qualify_timer.sv */
// qualifying-delay timer that arms the undervoltage request
`timescale 1ns/10ps
module qualify_timer
   import supply_monitor_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic enable,
   input wire logic low_flag,
   input wire logic [cnt_w-1:0] delay_cycles,
   // result
   output logic fire
);
   typedef struct packed
   {
      qual_state_e state;
      logic [cnt_w-1:0] count;
      logic fire;
   } qual_s;
   qual_s r;
   qual_s next_r;

   always_comb
   begin
      next_r = r;
      next_r.fire = 1'b0;
      if (!enable || !low_flag)
      begin
         // any return above threshold restarts the delay
         next_r.state = qual_idle;
         next_r.count = '0;
      end
      else
      begin
         case (r.state)
            qual_idle:
            begin
               next_r.state = qual_count;
               next_r.count = cnt_w'(1);
            end
            qual_count:
            begin
               if (r.count >= delay_cycles)
               begin
                  next_r.state = qual_done;
                  next_r.fire = 1'b1;
               end
               else
                  next_r.count = r.count + cnt_w'(1);
            end
            qual_done: next_r.state = qual_done;
            default: next_r.state = qual_idle;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         r <= '{qual_idle, '0, 1'b0};
      else
         r <= next_r;
   end

   assign fire = r.fire;
endmodule // qualify_timer

/* rtl/supply_monitor.sv */
// undervoltage detector control, status, interrupt and wake logic
`timescale 1ns/10ps
module supply_monitor
#(
   parameter int qualify_delay = supply_monitor_pkg::qualify_cycles
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // analog front end
   input wire logic comparator_low,
   output logic [supply_monitor_pkg::level_w-1:0] trip_level_select,
   output logic detector_power,
   output logic reference_power,
   // core side
   input wire logic stack_full,
   input wire logic irq_serviced,
   output logic irq_vector,
   output logic core_wake,
   output logic irq
);
   import supply_monitor_pkg::*;

   typedef struct packed
   {
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] ctrl;
      logic request;
      logic own_en;
      logic group_en;
      logic global_en;
      logic group_req;
      logic request_d;
      logic [st_w-1:0] status;
      logic [st_w-1:0] mask;
      logic vector;
      logic wake;
      logic irq;
      logic det_power;
      logic ref_power;
      logic [level_w-1:0] level;
   } mon_s;
   mon_s r;
   mon_s next_r;

   // register slots, so bus address decode is written once
   typedef enum logic [2:0]
   {
      slot_ctrl,
      slot_irq_ctrl,
      slot_status,
      slot_mask,
      slot_none
   } slot_e;

   logic comp_sync;
   logic qual_fire;
   logic low_flag;

   // the comparator itself is asynchronous to aclk
   level_sync i_level_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .raw_in(comparator_low),
      .sync_out(comp_sync)
   );

   // flag is forced low while the detector is off
   assign low_flag = comp_sync & r.ctrl[enable_bit];

   qualify_timer i_qualify_timer
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(r.ctrl[enable_bit]),
      .low_flag(low_flag),
      .delay_cycles(cnt_w'(qualify_delay)),
      .fire(qual_fire)
   );

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[i*8 +: 8] = data[i*8 +: 8];
      return res;
   endfunction

   function automatic logic [7:0] irq_image(input mon_s s);
      logic [7:0] img;
      img = '0;
      img[req_bit] = s.request;
      img[own_en_bit] = s.own_en;
      img[group_en_bit] = s.group_en;
      img[global_en_bit] = s.global_en;
      img[group_req_bit] = s.group_req;
      return img;
   endfunction

   // one decoder for both channels keeps the two maps in step
   function automatic slot_e decode_slot(input logic [7:0] addr);
      slot_e slot;
      case (addr)
         ctrl_addr: slot = slot_ctrl;
         irq_ctrl_addr: slot = slot_irq_ctrl;
         status_addr: slot = slot_status;
         mask_addr: slot = slot_mask;
         default: slot = slot_none;
      endcase
      return slot;
   endfunction

   // read image of one slot; unmapped slots read as zero
   function automatic logic [31:0] read_word(input mon_s s,
                                             input slot_e slot,
                                             input logic flag);
      logic [31:0] word;
      case (slot)
         slot_ctrl: word = {24'h0, ctrl_image(s.ctrl, flag)};
         slot_irq_ctrl: word = {24'h0, irq_image(s)};
         slot_status: word = {29'h0, s.status};
         slot_mask: word = {29'h0, s.mask};
         default: word = '0;
      endcase
      return word;
   endfunction

   // bus readies idle high so the first request is taken at once
   function automatic mon_s reset_state();
      mon_s s;
      s = '0;
      s.awready = 1'b1;
      s.wready = 1'b1;
      s.arready = 1'b1;
      s.ctrl = ctrl_reset;
      return s;
   endfunction

   always_comb
   begin
      logic do_write;
      logic [31:0] wv;
      logic [st_w-1:0] events;
      logic [st_w-1:0] w1c;
      logic req_set;
      logic req_clr;
      logic wr_req;
      logic vec_now;
      logic enables_set;
      do_write = 1'b0;
      wv = '0;
      events = '0;
      w1c = '0;
      req_set = 1'b0;
      req_clr = 1'b0;
      wr_req = 1'b0;
      vec_now = 1'b0;
      enables_set = 1'b0;
      next_r = r;

      // write channel: address and data in either order
      // readies stay low until the response is taken, one write at once
      if (s_axi_awvalid && r.awready)
      begin
         next_r.aw_held = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
         next_r.awready = 1'b0;
      end
      if (s_axi_wvalid && r.wready)
      begin
         next_r.w_held = 1'b1;
         next_r.w_data = s_axi_wdata;
         next_r.w_strb = s_axi_wstrb;
         next_r.wready = 1'b0;
      end
      if (r.aw_held && r.w_held && !r.bvalid)
      begin
         do_write = 1'b1;
         next_r.aw_held = 1'b0;
         next_r.w_held = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = resp_okay;
      end
      if (r.bvalid && s_axi_bready)
      begin
         next_r.bvalid = 1'b0;
         next_r.awready = 1'b1;
         next_r.wready = 1'b1;
      end

      if (do_write)
      begin
         case (decode_slot(r.aw_addr))
            slot_ctrl:
            begin
               wv = merge({24'h0, r.ctrl}, r.w_data, r.w_strb);
               next_r.ctrl = wv[7:0] & ctrl_write_mask;
            end
            slot_irq_ctrl:
            begin
               wv = merge({24'h0, irq_image(r)}, r.w_data, r.w_strb);
               wr_req = 1'b1;
               req_set = wv[req_bit];
               req_clr = !wv[req_bit];
               next_r.own_en = wv[own_en_bit];
               next_r.group_en = wv[group_en_bit];
               next_r.global_en = wv[global_en_bit];
               next_r.group_req = wv[group_req_bit];
            end
            slot_status:
            begin
               // status clears through byte 0 only
               if (r.w_strb[0])
                  w1c = r.w_data[st_w-1:0];
            end
            slot_mask:
            begin
               wv = merge({29'h0, r.mask}, r.w_data, r.w_strb);
               next_r.mask = wv[st_w-1:0];
            end
            default: next_r.bresp = resp_slverr;
         endcase
      end

      // request flag: hardware set wins over software clear
      if (qual_fire)
         next_r.request = 1'b1;
      else if (wr_req && req_clr)
         next_r.request = 1'b0;
      else if (wr_req && req_set)
         next_r.request = 1'b1;
      // delayed copy for the wake edge; both reset low, so no false edge
      next_r.request_d = r.request;

      // wake on any rising request, enables ignored
      next_r.wake = r.request && !r.request_d;

      // every enable and the group request must stand, and the stack
      // must have room, or the core would lose its return address
      enables_set = r.own_en && r.group_en && r.global_en;
      vec_now = r.request && r.group_req && enables_set &&
                !stack_full;
      next_r.vector = vec_now;
      if (irq_serviced)
      begin
         // the core's service clears these, own flag stays
         next_r.global_en = 1'b0;
         next_r.group_req = 1'b0;
      end
      // a new request in the cycle of service must not be lost
      if (qual_fire)
         next_r.group_req = 1'b1;

      events[st_request_bit] = qual_fire;
      events[st_wake_bit] = r.wake;
      events[st_vector_bit] = vec_now && !r.vector;
      next_r.status = (r.status & ~w1c) | events;
      // taken from the next status so irq follows a clear at once
      next_r.irq = |(next_r.status & next_r.mask);

      next_r.det_power = next_r.ctrl[enable_bit];
      next_r.ref_power = next_r.ctrl[enable_bit];
      next_r.level = next_r.ctrl[level_lsb +: level_w];

      // read channel
      // arready stays low until rdata is taken, one read at a time
      if (s_axi_arvalid && r.arready)
      begin
         next_r.arready = 1'b0;
         next_r.rvalid = 1'b1;
         next_r.rresp = resp_okay;
         next_r.rdata = read_word(r, decode_slot(s_axi_araddr), low_flag);
         if (decode_slot(s_axi_araddr) == slot_none)
            next_r.rresp = resp_slverr;
      end
      if (r.rvalid && s_axi_rready)
      begin
         next_r.rvalid = 1'b0;
         next_r.arready = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         r <= reset_state();
      else
         r <= next_r;
   end

   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bresp = r.bresp;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_arready = r.arready;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign s_axi_rvalid = r.rvalid;
   assign trip_level_select = r.level;
   assign detector_power = r.det_power;
   assign reference_power = r.ref_power;
   assign irq_vector = r.vector;
   assign core_wake = r.wake;
   assign irq = r.irq;
endmodule // supply_monitor

/* verification/supply_monitor_asserts.sv */
// concurrent checks on the supply monitor top-level ports
`timescale 1ns/10ps
module supply_monitor_asserts
#(
   parameter int qualify_delay = 8
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // front end and core
   input wire logic comparator_low,
   input wire logic detector_power,
   input wire logic reference_power,
   input wire logic stack_full,
   input wire logic irq_serviced,
   input wire logic irq_vector,
   input wire logic core_wake,
   input wire logic irq
);
   int comp_run;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // saturates so a long brown-out cannot wrap the count
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !comparator_low || !detector_power)
         comp_run <= 0;
      else if (comp_run < 1000)
         comp_run <= comp_run + 1;
   end

   sequence s_stack_held;
      stack_full [*2];
   endsequence
   sequence s_recent_write;
      !$past(s_axi_wready) || !$past(s_axi_wready, 2);
   endsequence

   property p_ref_power;
      detector_power == reference_power;
   endproperty
   a_ref_power: assert property (p_ref_power)
      else $error("reference power differs from detector");
   property p_wake_pulse;
      core_wake |=> !core_wake;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse)
      else $error("wake longer than one cycle");
   property p_vector_stack;
      s_stack_held |=> !irq_vector;
   endproperty
   a_vector_stack: assert property (p_vector_stack)
      else $error("vector while stack full");
   property p_vector_serviced;
      irq_serviced |-> ##2 !irq_vector;
   endproperty
   a_vector_serviced: assert property (p_vector_serviced)
      else $error("vector stays after service");
   property p_irq_clear;
      $fell(irq) |-> s_recent_write;
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("irq dropped without a write");
   property p_wake_cause;
      core_wake |-> comp_run >= qualify_delay || !$past(s_axi_wready)
         || !$past(s_axi_wready, 2) || !$past(s_axi_wready, 3);
   endproperty
   a_wake_cause: assert property (p_wake_cause)
      else $error("wake before qualifying delay");
   property p_b_once;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_once: assert property (p_b_once)
      else $error("second write response");
   property p_r_once;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_once: assert property (p_r_once)
      else $error("second read response");
endmodule // supply_monitor_asserts

/* verification/tb_top.sv */
// self-checking bench for the supply monitor
`timescale 1ns/10ps
module tb_top;
   import supply_monitor_pkg::*;
   localparam int qdelay = 8;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic comparator_low = 1'h0, stack_full = 1'h0, irq_serviced = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, detector_power, reference_power;
   logic irq_vector, core_wake, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [2:0] trip_level_select;
   int miscompares = 0, samples_checked = 0, wakes = 0;

   supply_monitor #(.qualify_delay(qdelay)) i_supply_monitor
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .comparator_low, .trip_level_select,
      .detector_power, .reference_power, .stack_full, .irq_serviced,
      .irq_vector, .core_wake, .irq
   );

   always #25 aclk = ~aclk;
   always @(posedge aclk) if (core_wake === 1'h1) wakes++;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic timeout(input logic hung);
      if (hung)
      begin
         miscompares++;
         close_out();
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end
      while (s_axi_bvalid !== 1'h1 && n < 50);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
      timeout(s_axi_bvalid !== 1'h1);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'h0;
      end
      while (s_axi_rvalid !== 1'h1 && n < 50);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
      timeout(s_axi_rvalid !== 1'h1);
      chk(rd, exp);
   endtask

   initial
   begin
      cyc(4);
      aresetn <= 1'h1;
      for (int i = 0; i < 4; i++)
         rchk(8'(4 * i), 32'h0);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         wr(ctrl_addr, 32'hf8 | 32'(i));
         rchk(ctrl_addr, 32'h10 | 32'(i));
         chk(32'(trip_level_select), 32'(i));
         chk(32'({detector_power, reference_power}), 32'h3);
      end
      wr(ctrl_addr, 32'h0);
      comparator_low <= 1'h1;
      cyc(20);
      rchk(ctrl_addr, 32'h0);
      chk(32'(reference_power), 32'h0);
      rchk(status_addr, 32'h0);
      comparator_low <= 1'h0;
      $display("test control done");
      wr(ctrl_addr, 32'h13);
      comparator_low <= 1'h1;
      cyc(qdelay / 2);
      comparator_low <= 1'h0;
      cyc(20);
      rchk(status_addr, 32'h0);
      comparator_low <= 1'h1;
      cyc(4);
      rchk(ctrl_addr, 32'h33);
      cyc(3 * qdelay);
      rchk(status_addr, 32'h3);
      chk(32'(wakes), 32'h1);
      comparator_low <= 1'h0;
      cyc(4);
      rchk(ctrl_addr, 32'h13);
      wr(mask_addr, 32'h1);
      cyc(3);
      chk(32'(irq), 32'h1);
      wr(status_addr, 32'h7);
      cyc(3);
      chk(32'(irq), 32'h0);
      rchk(irq_ctrl_addr, 32'h11);
      $display("test qualify done");
      // request already high, so a new brown-out must not wake again
      comparator_low <= 1'h1;
      cyc(3 * qdelay);
      comparator_low <= 1'h0;
      chk(32'(wakes), 32'h1);
      wr(irq_ctrl_addr, 32'h0);
      wr(irq_ctrl_addr, 32'h1);
      cyc(3);
      chk(32'(wakes), 32'h2);
      $display("test wake done");
      wr(irq_ctrl_addr, 32'h1b);
      cyc(3);
      chk(32'(irq_vector), 32'h0);
      wr(irq_ctrl_addr, 32'h1f);
      cyc(3);
      chk(32'(irq_vector), 32'h1);
      stack_full <= 1'h1;
      cyc(3);
      chk(32'(irq_vector), 32'h0);
      stack_full <= 1'h0;
      cyc(3);
      irq_serviced <= 1'h1;
      cyc(1);
      irq_serviced <= 1'h0;
      cyc(3);
      chk(32'(irq_vector), 32'h0);
      rchk(irq_ctrl_addr, 32'h7);
      $display("test vector done");
      wr(8'h40, 32'hffffffff);
      chk(32'(resp), 32'(resp_slverr));
      rchk(8'h40, 32'h0);
      chk(32'(resp), 32'(resp_slverr));
      $display("test unmapped done");
      close_out();
   end
endmodule // tb_top

bind supply_monitor supply_monitor_asserts #(.qualify_delay(qualify_delay))
   i_supply_monitor_asserts
(
   .aclk, .aresetn, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_rvalid, .s_axi_rready, .comparator_low, .detector_power,
   .reference_power, .stack_full, .irq_serviced, .irq_vector, .core_wake,
   .irq
);
